// File: src/dmss_pkg.sv
// package for the drive monitor and serial setup block: map, fields, timing
package dmss_pkg;
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned TICK_MS       = 10;
	localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned AVG_MS        = 1000;
	localparam int unsigned AVG_SAMPLES   = AVG_MS / TICK_MS;
	localparam int unsigned BAUD_MAX      = 9600;
	localparam int unsigned BAUD_MIN      = 300;

	localparam logic [7:0] A_AVG_SPEED   = 8'h00;
	localparam logic [7:0] A_DEVIATION   = 8'h04;
	localparam logic [7:0] A_SCALED_REF  = 8'h08;
	localparam logic [7:0] A_RAMPED_REF  = 8'h0c;
	localparam logic [7:0] A_DRIVE_PCT   = 8'h10;
	localparam logic [7:0] A_PID_TRIM    = 8'h14;
	localparam logic [7:0] A_LOOP_TOTAL  = 8'h18;
	localparam logic [7:0] A_STATUS_HOT  = 8'h1c;
	localparam logic [7:0] A_STORE_STAT  = 8'h20;
	localparam logic [7:0] A_OVF_COUNT   = 8'h24;
	localparam logic [7:0] A_CURRENT     = 8'h28;
	localparam logic [7:0] A_SERIAL_ERR  = 8'h2c;
	localparam logic [7:0] A_SERIAL_CFG  = 8'h30;
	localparam logic [7:0] A_MODE_CTRL   = 8'h34;
	localparam logic [7:0] A_SCALE_CFG   = 8'h38;
	localparam logic [7:0] A_OVF_CLEAR   = 8'h3c;

	localparam logic [5:0] ADDR_DEF      = 6'h01;
	localparam logic [5:0] ADDR_MIN      = 6'h01;
	localparam logic [5:0] ADDR_MAX      = 6'h20;
	localparam logic [5:0] ADDR_BCAST    = 6'h00;
	localparam logic [2:0] RATE_DEF      = 3'h6;
	localparam logic [2:0] RATE_MIN      = 3'h1;
	localparam logic [2:0] RATE_MAX      = 3'h6;
	localparam logic [1:0] FMT_DEF       = 2'h1;
	localparam logic [1:0] FMT_MIN       = 2'h1;
	localparam logic [1:0] FMT_MAX       = 2'h3;
	localparam logic [1:0] MASK_DEF      = 2'h0;
	localparam logic [15:0] PCT_FULL     = 16'h0064;
	localparam logic [15:0] COUNTS_FULL  = 16'h1000;
	localparam logic [31:0] DISP_LIMIT   = 32'h0000270f;
	localparam logic [31:0] DISP_DIV     = 32'h00000064;
	localparam logic [7:0] SERR_BASE     = 8'h40;

	typedef enum logic [1:0] {DMSS_DIRECT, DMSS_MASTER, DMSS_FOLLOWER} dmss_scale_t;
	typedef enum logic [1:0] {DMSS_FSTOP, DMSS_RSTOP, DMSS_RUN, DMSS_JOG} dmss_ctl_t;

	typedef struct packed {
		logic [5:0] station_address;
		logic [2:0] bit_rate_code;
		logic [1:0] char_format_code;
		logic [1:0] serial_control_mask;
	} dmss_cfg_t;

	typedef struct packed {
		logic       valid;
		logic [5:0] dest;
		logic       run_cmd;
		logic       rstop_cmd;
		logic       fstop_cmd;
		logic       mf_cmd;
		logic       sps_cmd;
		logic [7:0] err_bits;
	} dmss_msg_t;

	typedef struct packed {
		logic       accept;
		logic       reply;
		logic       run_ok;
		logic       rstop_ok;
		logic       fstop_ok;
		logic       mf_ok;
		logic       sps_ok;
	} dmss_act_t;

	typedef struct packed {
		logic [3:0] data_bits;
		logic       parity_even;
		logic [1:0] stop_bits;
		logic [19:0] bit_cycles;
	} dmss_frame_t;
endpackage

// File: src/dmss_top.sv
// apb slave holding monitor values and serial setup of the speed drive
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module dmss_top #(
	parameter int unsigned TICK_LEN = dmss_pkg::TICK_CYCLES,
	parameter int unsigned AVG_LEN  = dmss_pkg::AVG_SAMPLES
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [15:0]           feedback_hz,
	input  wire logic [15:0]           lead_hz,
	input  wire logic [31:0]           scaled_setpoint_in,
	input  wire logic [31:0]           ramped_setpoint_in,
	input  wire logic signed [15:0]    pid_trim_in,
	input  wire logic signed [15:0]    feedforward_in,
	input  wire logic [15:0]           armature_rms_current,
	input  wire logic                  current_limit_flag,
	input  wire logic [7:0]            alarm_onehot,
	input  wire logic [7:0]            entry_reject_cause,
	input  wire logic                  store_verify_fail,
	input  wire logic                  freq_overflow,
	input  wire logic                  clear_key,
	input  wire logic                  jog_active,
	input  wire dmss_pkg::dmss_ctl_t   control_state,
	input  wire dmss_pkg::dmss_msg_t   rx_msg,
	output dmss_pkg::dmss_act_t        rx_action,
	output dmss_pkg::dmss_cfg_t        serial_cfg,
	output dmss_pkg::dmss_frame_t      frame_cfg,
	output logic                       sample_tick,
	output logic [31:0]                averaged_speed_display,
	output logic [3:0]                 control_state_onehot,
	output logic [2:0]                 scaling_mode_onehot
);
	import dmss_pkg::*;

	function automatic logic [31:0] disp_fmt(input logic [31:0] v);
		disp_fmt = (v > DISP_LIMIT) ? {1'b1, 31'(v / DISP_DIV)} : v;
	endfunction

	function automatic logic [15:0] pct_of(input logic signed [16:0] c);
		logic signed [31:0] p;
		p = 32'(c) * 32'(PCT_FULL);
		pct_of = (c <= 0) ? 16'h0000 : 16'(p / 32'(COUNTS_FULL));
	endfunction

	logic [31:0]        tick_cnt_ff;
	logic [31:0]        nxt_tick_cnt;
	logic               tick_ff;
	logic [31:0]        samp_cnt_ff;
	logic [31:0]        acc_ff;
	logic [31:0]        avg_ff;
	logic signed [31:0] dev_ff;
	logic signed [16:0] total_ff;
	logic [15:0]        ovf_cnt_ff;
	logic               store_ff;
	logic [7:0]         serr_ff;
	dmss_cfg_t          cfg_ff;
	dmss_scale_t        mode_ff;
	logic               fol_sel_ff;
	logic [15:0]        mscale_ff;
	logic [15:0]        fscale_ff;
	logic [31:0]        rdata_ff;

	// apb decode
	wire                acc_phase = psel & penable;
	wire                wr_en     = acc_phase & pwrite & pstrb[0];
	wire                wr_cfg    = wr_en && paddr == A_SERIAL_CFG;
	wire                wr_mode   = wr_en && paddr == A_MODE_CTRL;
	wire                wr_scale  = wr_en && paddr == A_SCALE_CFG;
	wire                wr_clr    = wr_en && paddr == A_OVF_CLEAR;
	wire                mapped    = paddr <= A_OVF_CLEAR && paddr[1:0] == 2'b00;

	// setup value checks, out-of-range writes keep the old value
	wire [5:0]          w_addr    = pwdata[5:0];
	wire [2:0]          w_rate    = pwdata[10:8];
	wire [1:0]          w_fmt     = pwdata[17:16];
	wire [1:0]          w_mask    = pwdata[25:24];
	wire                addr_ok   = w_addr >= ADDR_MIN && w_addr <= ADDR_MAX;
	wire                rate_ok   = w_rate >= RATE_MIN && w_rate <= RATE_MAX;
	wire                fmt_ok    = w_fmt >= FMT_MIN && w_fmt <= FMT_MAX;

	// tick and average
	wire                tick_wrap = tick_cnt_ff == 32'(TICK_LEN - 1);
	wire                avg_wrap  = samp_cnt_ff == 32'(AVG_LEN - 1);
	wire [31:0]         acc_sum   = acc_ff + 32'(feedback_hz);
	// zero lead only guarded, any other lead divides with the remainder dropped
	wire [15:0]         lead_div  = (lead_hz == 16'h0000) ? 16'h0001 : lead_hz;
	wire [31:0]         fb_avg    = 32'(acc_sum / 32'(AVG_LEN));
	// jog shows plain hz whatever the scaling mode
	wire [31:0]         fb_units  = (mode_ff == DMSS_DIRECT || jog_active) ? fb_avg :
	                                (mode_ff == DMSS_FOLLOWER && fol_sel_ff) ?
	                                32'(feedback_hz) * 32'(fscale_ff) / 32'(lead_div) :
	                                fb_avg * 32'(mscale_ff) / 32'(COUNTS_FULL);

	assign nxt_tick_cnt = tick_wrap ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_ff <= 32'h0000_0000;
			tick_ff     <= 1'b0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
			tick_ff     <= tick_wrap;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_cnt_ff <= 32'h0000_0000;
			acc_ff      <= 32'h0000_0000;
			avg_ff      <= 32'h0000_0000;
		end else if (tick_ff) begin
			samp_cnt_ff <= avg_wrap ? 32'h0000_0000 : samp_cnt_ff + 32'h0000_0001;
			acc_ff      <= avg_wrap ? 32'h0000_0000 : acc_sum;
			if (avg_wrap) begin
				avg_ff <= fb_units;
			end
		end
	end

	// unfiltered per-tick values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_ff   <= 32'sh0000_0000;
			total_ff <= 17'sh0_0000;
		end else if (tick_ff) begin
			dev_ff   <= $signed(ramped_setpoint_in) - $signed(32'(feedback_hz));
			total_ff <= 17'(pid_trim_in) + 17'(feedforward_in);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_cnt_ff <= 16'h0000;
			store_ff   <= 1'b0;
		end else begin
			if (freq_overflow) begin
				ovf_cnt_ff <= ovf_cnt_ff + 16'h0001;
			end else if (clear_key || wr_clr) begin
				ovf_cnt_ff <= 16'h0000;
			end
			if (store_verify_fail) begin
				store_ff <= 1'b1;
			end
		end
	end

	// serial setup registers, factory defaults at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= '{ADDR_DEF, RATE_DEF, FMT_DEF, MASK_DEF};
		end else if (wr_cfg) begin
			if (addr_ok) cfg_ff.station_address <= w_addr;
			if (rate_ok) cfg_ff.bit_rate_code <= w_rate;
			if (fmt_ok) cfg_ff.char_format_code <= w_fmt;
			cfg_ff.serial_control_mask <= w_mask;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff    <= DMSS_DIRECT;
			fol_sel_ff <= 1'b0;
			mscale_ff  <= COUNTS_FULL;
			fscale_ff  <= COUNTS_FULL;
		end else begin
			if (wr_mode && pwdata[1:0] <= 2'(DMSS_FOLLOWER)) begin
				mode_ff    <= dmss_scale_t'(pwdata[1:0]);
				fol_sel_ff <= pwdata[4];
			end
			if (wr_scale) begin
				mscale_ff <= pwdata[15:0];
				fscale_ff <= pwdata[31:16];
			end
		end
	end

	// message acceptance, broadcast and command mask
	wire                to_me    = rx_msg.dest == cfg_ff.station_address;
	wire                is_bcast = rx_msg.dest == ADDR_BCAST;
	wire                no_err   = rx_msg.err_bits == SERR_BASE;
	wire [1:0]          mk       = cfg_ff.serial_control_mask;

	assign rx_action.accept   = rx_msg.valid & (to_me | is_bcast) & no_err;
	assign rx_action.reply    = rx_msg.valid & to_me & ~is_bcast;
	assign rx_action.fstop_ok = rx_action.accept & rx_msg.fstop_cmd;
	assign rx_action.run_ok   = rx_action.accept & rx_msg.run_cmd & mk[0];
	assign rx_action.rstop_ok = rx_action.accept & rx_msg.rstop_cmd & mk[0];
	assign rx_action.mf_ok    = rx_action.accept & rx_msg.mf_cmd & mk[1];
	assign rx_action.sps_ok   = rx_action.accept & rx_msg.sps_cmd & mk[1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serr_ff <= SERR_BASE;
		end else if (rx_msg.valid && (to_me || is_bcast)) begin
			serr_ff <= rx_msg.err_bits;
		end
	end

	// frame settings from codes
	wire [31:0]         baud     = 32'(BAUD_MIN) << (cfg_ff.bit_rate_code - RATE_MIN);
	assign frame_cfg.data_bits   = (cfg_ff.char_format_code == 2'h2) ? 4'h7 : 4'h8;
	assign frame_cfg.parity_even = cfg_ff.char_format_code == 2'h2;
	assign frame_cfg.stop_bits   = (cfg_ff.char_format_code == FMT_MAX) ? 2'h2 : 2'h1;
	assign frame_cfg.bit_cycles  = 20'(32'(CLK_HZ) / baud);

	// read mux
	wire [31:0] rd_val =
		(paddr == A_AVG_SPEED)  ? avg_ff :
		(paddr == A_DEVIATION)  ? dev_ff :
		(paddr == A_SCALED_REF) ? disp_fmt(scaled_setpoint_in) :
		(paddr == A_RAMPED_REF) ? disp_fmt(ramped_setpoint_in) :
		(paddr == A_DRIVE_PCT)  ? {16'h0000, pct_of(total_ff)} :
		(paddr == A_PID_TRIM)   ? 32'(pid_trim_in) :
		(paddr == A_LOOP_TOTAL) ? 32'(total_ff) :
		(paddr == A_STATUS_HOT) ? {8'h00, entry_reject_cause, alarm_onehot, 1'b0,
		                           scaling_mode_onehot, control_state_onehot} :
		(paddr == A_STORE_STAT) ? {31'h0000_0000, store_ff} :
		(paddr == A_OVF_COUNT)  ? {16'h0000, ovf_cnt_ff} :
		(paddr == A_CURRENT)    ? {15'h0000, current_limit_flag, armature_rms_current} :
		(paddr == A_SERIAL_ERR) ? {24'h00_0000, serr_ff} :
		(paddr == A_SERIAL_CFG) ? {6'h00, cfg_ff.serial_control_mask, 6'h00,
		                           cfg_ff.char_format_code, 5'h00, cfg_ff.bit_rate_code,
		                           2'h0, cfg_ff.station_address} :
		(paddr == A_MODE_CTRL)  ? {27'h000_0000, fol_sel_ff, 2'h0, 2'(mode_ff)} :
		(paddr == A_SCALE_CFG)  ? {fscale_ff, mscale_ff} :
		32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			rdata_ff <= rd_val;
		end
	end

	assign prdata                 = rdata_ff;
	assign pready                 = 1'b1;
	assign pslverr                = acc_phase & ~mapped;
	assign serial_cfg             = cfg_ff;
	assign sample_tick            = tick_ff;
	assign averaged_speed_display = avg_ff;
	assign control_state_onehot   = 4'h1 << control_state;
	assign scaling_mode_onehot    = 3'h1 << mode_ff;
endmodule

// File: verification/dmss_host_model.sv
// host computer model issuing decoded serial messages
`timescale 1ns/1ps
module dmss_host_model (
	input  wire logic          pclk,
	output dmss_pkg::dmss_msg_t rx_msg
);
	import dmss_pkg::*;
	initial rx_msg = '0;
	// one message per call, idle lines toggled afterwards
	task automatic send(input logic [5:0] dest, input logic [4:0] cmd, input logic [7:0] err);
		rx_msg <= {1'b1, dest, cmd, err};
		@(posedge pclk);
		rx_msg <= {1'b0, ~dest, ~cmd, ~err};
		@(posedge pclk);
	endtask
endmodule

// File: verification/dmss_properties.sv
// checker of bus, serial address and setup rules
`timescale 1ns/1ps
module dmss_checker #(
	parameter int unsigned TICK_LEN = 10
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic [7:0]            paddr,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire dmss_pkg::dmss_msg_t   rx_msg,
	input wire dmss_pkg::dmss_act_t   rx_action,
	input wire dmss_pkg::dmss_cfg_t   serial_cfg,
	input wire dmss_pkg::dmss_frame_t frame_cfg,
	input wire logic                  sample_tick,
	input wire logic [31:0]           averaged_speed_display,
	input wire logic [3:0]            control_state_onehot,
	input wire logic [2:0]            scaling_mode_onehot
);
	import dmss_pkg::*;
	// clock cycles per serial bit from the rate code table
	function automatic logic [19:0] bit_len(input logic [2:0] code);
		int unsigned rate;
		case (code)
			3'h1: rate = 300;
			3'h2: rate = 600;
			3'h3: rate = 1200;
			3'h4: rate = 2400;
			3'h5: rate = 4800;
			default: rate = 9600;
		endcase
		bit_len = 20'(CLK_HZ / rate);
	endfunction
	logic [31:0] gap_ff;
	logic        seen_ff;
	wire  [31:0] nxt_gap = sample_tick ? 32'h0 : gap_ff + 32'h1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_ff <= 32'h0;
			seen_ff <= 1'b0;
		end else begin
			gap_ff <= nxt_gap;
			seen_ff <= seen_ff | sample_tick;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_bad_req;
		psel && !penable && (paddr > 8'h3c || paddr[1:0] != 2'h0);
	endsequence
	sequence s_good_req;
		psel && !penable && paddr <= 8'h3c && paddr[1:0] == 2'h0;
	endsequence
	a_bad_errs: assert property (s_bad_req ##1 penable |-> pslverr)
		else $error("unmapped access without error");
	a_good_clean: assert property (s_good_req ##1 penable |-> !pslverr)
		else $error("mapped access flagged");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	a_ready_high: assert property (psel && penable |-> pready)
		else $error("access not answered");
	a_bcast_silent: assert property (rx_msg.valid && rx_msg.dest == 6'h00
		|-> !rx_action.reply && rx_action.accept == (rx_msg.err_bits == SERR_BASE))
		else $error("broadcast handling wrong");
	a_own_reply: assert property (rx_msg.valid &&
		rx_msg.dest == serial_cfg.station_address
		|-> rx_action.reply && rx_action.accept == (rx_msg.err_bits == SERR_BASE))
		else $error("own message not taken");
	a_foreign_drop: assert property (rx_msg.valid && rx_msg.dest != 6'h00 &&
		rx_msg.dest != serial_cfg.station_address |-> !rx_action.accept && !rx_action.reply)
		else $error("foreign message taken");
	a_addr_range: assert property (serial_cfg.station_address >= 6'h01 &&
		serial_cfg.station_address <= 6'h20)
		else $error("station address out of range");
	a_rate_range: assert property (serial_cfg.bit_rate_code >= 3'h1 &&
		serial_cfg.bit_rate_code <= 3'h6)
		else $error("bit rate code out of range");
	a_rate_cycles: assert property (frame_cfg.bit_cycles == bit_len(serial_cfg.bit_rate_code))
		else $error("bit length wrong");
	a_fmt_frame: assert property (
		frame_cfg.data_bits == (serial_cfg.char_format_code == 2'h2 ? 4'h7 : 4'h8) &&
		frame_cfg.parity_even == (serial_cfg.char_format_code == 2'h2) &&
		frame_cfg.stop_bits == (serial_cfg.char_format_code == 2'h3 ? 2'h2 : 2'h1))
		else $error("character frame wrong");
	a_mask_gate: assert property (
		(!(rx_action.run_ok || rx_action.rstop_ok) || serial_cfg.serial_control_mask[0]) &&
		(!(rx_action.mf_ok || rx_action.sps_ok) || serial_cfg.serial_control_mask[1]))
		else $error("command passed the mask");
	a_onehot_disp: assert property ($onehot(scaling_mode_onehot) && $onehot(control_state_onehot))
		else $error("status display not one-hot");
	a_avg_hold: assert property (!sample_tick |=> $stable(averaged_speed_display))
		else $error("average changed off tick");
	a_tick_period: assert property (sample_tick && seen_ff |-> gap_ff == TICK_LEN - 1)
		else $error("tick period wrong");
	a_tick_gap: assert property (seen_ff |-> gap_ff < TICK_LEN)
		else $error("tick missing");
endmodule
bind dmss_top dmss_checker #(.TICK_LEN(TICK_LEN)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.rx_msg(rx_msg), .rx_action(rx_action), .serial_cfg(serial_cfg), .frame_cfg(frame_cfg),
	.sample_tick(sample_tick), .averaged_speed_display(averaged_speed_display),
	.control_state_onehot(control_state_onehot), .scaling_mode_onehot(scaling_mode_onehot));

// File: verification/test_drive_monitor_and_serial_setup.sv
// self-checking bench of the drive monitor and serial setup block
`timescale 1ns/1ps
module test_drive_monitor_and_serial_setup;
	import dmss_pkg::*;
	localparam int unsigned TL = 10;
	localparam int unsigned AL = 4;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0] paddr = 0, alarm_onehot = 0, entry_reject_cause = 0;
	logic [31:0] pwdata = 0, prdata, scaled_setpoint_in = 0, ramped_setpoint_in = 0;
	logic [31:0] averaged_speed_display;
	logic [3:0] pstrb = 4'hf, control_state_onehot;
	logic [2:0] scaling_mode_onehot;
	logic [15:0] feedback_hz = 0, lead_hz = 16'h0100, armature_rms_current = 0, rv;
	logic signed [15:0] pid_trim_in = 0, feedforward_in = 0;
	logic current_limit_flag = 0, store_verify_fail = 0, freq_overflow = 0;
	logic clear_key = 0, jog_active = 0, sample_tick;
	dmss_ctl_t control_state = DMSS_RSTOP;
	dmss_msg_t rx_msg;
	dmss_act_t rx_action;
	dmss_cfg_t serial_cfg;
	dmss_frame_t frame_cfg;
	logic [32:0] rd_q[$];
	dmss_act_t act_q[$];
	int fails = 0, cmp_count = 0, n;
	integer seed = 32'h7af464fe;
	logic [1:0] em = MASK_DEF, ef = FMT_DEF;
	logic [2:0] er = RATE_DEF;
	logic [5:0] ea = ADDR_DEF;
	always #5 pclk = ~pclk;
	dmss_top #(.TICK_LEN(TL), .AVG_LEN(AL)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .feedback_hz, .lead_hz,
		.scaled_setpoint_in, .ramped_setpoint_in, .pid_trim_in, .feedforward_in,
		.armature_rms_current, .current_limit_flag, .alarm_onehot, .entry_reject_cause,
		.store_verify_fail, .freq_overflow, .clear_key, .jog_active, .control_state, .rx_msg,
		.rx_action, .serial_cfg, .frame_cfg, .sample_tick, .averaged_speed_display,
		.control_state_onehot, .scaling_mode_onehot);
	dmss_host_model host (.pclk, .rx_msg);
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk_rd(input logic [32:0] e);
		cmp_count++;
		if (e[32] ? pslverr !== 1'b1 : prdata !== e[31:0]) begin
			fails++;
			$display("MISMATCH prdata expected %h seen %h err %b", e, prdata, pslverr);
		end
	endtask
	task automatic chk_act(input dmss_act_t e);
		cmp_count++;
		if (rx_action !== e) begin
			fails++;
			$display("MISMATCH rx_action expected %b seen %b", e, rx_action);
		end
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) chk_rd(rd_q.pop_front());
		if (rx_msg.valid) chk_act(act_q.pop_front());
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back({1'b0, e});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic bad(input logic [7:0] a);
		rd_q.push_back({1'b1, 32'h0});
		apb(1'b0, a, 32'h0);
	endtask
	function automatic logic [31:0] pack(logic [1:0] m, logic [1:0] f, logic [2:0] r,
		logic [5:0] a);
		return {6'h0, m, 6'h0, f, 5'h0, r, 2'h0, a};
	endfunction
	task automatic setc(input logic [1:0] m, input logic [1:0] f, input logic [2:0] r,
		input logic [5:0] a);
		wr(A_SERIAL_CFG, pack(m, f, r, a));
		em = m;
		if (f >= FMT_MIN && f <= FMT_MAX) ef = f;
		if (r >= RATE_MIN && r <= RATE_MAX) er = r;
		if (a >= ADDR_MIN && a <= ADDR_MAX) ea = a;
		rd(A_SERIAL_CFG, pack(em, ef, er, ea));
	endtask
	task automatic msg(input logic [5:0] d, input logic [7:0] err);
		logic acc;
		acc = (d == 6'h00 || d == ea) && err == SERR_BASE;
		act_q.push_back({acc, d == ea, {2{acc & em[0]}}, acc, {2{acc & em[1]}}});
		host.send(d, 5'h1f, err);
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		fails++;
		stop_test;
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(A_SERIAL_CFG, pack(MASK_DEF, FMT_DEF, RATE_DEF, ADDR_DEF));
		rd(A_SERIAL_ERR, 32'h40);
		rd(A_STORE_STAT, 32'h0);
		rd(A_OVF_COUNT, 32'h0);
		bad(8'h40);
		bad(8'h05);
		for (int i = 0; i < 8; i++) setc(2'h0, 2'h1, i[2:0], 6'h05);
		for (int i = 0; i < 4; i++) setc(2'h0, i[1:0], 3'h6, 6'h05);
		setc(2'h0, 2'h1, 3'h6, 6'h00);
		setc(2'h0, 2'h1, 3'h6, 6'h21);
		for (int i = 0; i < 4; i++) begin
			setc(i[1:0], 2'h1, 3'h6, 6'h20);
			msg(6'h20, 8'h40);
			msg(6'h00, 8'h40);
			msg(6'h07, 8'h40);
		end
		msg(6'h20, 8'h50);
		rd(A_SERIAL_ERR, 32'h50);
		msg(6'h07, 8'h48);
		rd(A_SERIAL_ERR, 32'h50);
		msg(6'h00, 8'h40);
		rd(A_SERIAL_ERR, 32'h40);
		n = 1 + ($random(seed) & 3);
		repeat (n) begin
			freq_overflow <= 1'b1;
			@(posedge pclk);
			freq_overflow <= 1'b0;
			@(posedge pclk);
		end
		rd(A_OVF_COUNT, n);
		wr(A_OVF_CLEAR, 32'h1);
		rd(A_OVF_COUNT, 32'h0);
		freq_overflow <= 1'b1;
		store_verify_fail <= 1'b1;
		@(posedge pclk);
		freq_overflow <= 1'b0;
		store_verify_fail <= 1'b0;
		clear_key <= 1'b1;
		@(posedge pclk);
		clear_key <= 1'b0;
		rd(A_OVF_COUNT, 32'h0);
		rd(A_STORE_STAT, 32'h1);
		rv = 16'($random(seed));
		feedback_hz <= {4'h1, rv[11:0]};
		armature_rms_current <= rv;
		current_limit_flag <= 1'b1;
		ramped_setpoint_in <= 32'd10000;
		scaled_setpoint_in <= 32'd9999;
		pid_trim_in <= 16'sh0800;
		feedforward_in <= 16'sh0800;
		alarm_onehot <= 8'h04;
		entry_reject_cause <= 8'h02;
		control_state <= DMSS_RUN;
		repeat (2 * (AL + 1) * TL) @(posedge pclk);
		rd(A_AVG_SPEED, {16'h0, 4'h1, rv[11:0]});
		rd(A_DEVIATION, 32'd10000 - {16'h0, 4'h1, rv[11:0]});
		rd(A_SCALED_REF, 32'd9999);
		rd(A_RAMPED_REF, 32'h80000064);
		rd(A_PID_TRIM, 32'h800);
		rd(A_LOOP_TOTAL, 32'h1000);
		rd(A_DRIVE_PCT, 32'd100);
		rd(A_STATUS_HOT, 32'h00020414);
		rd(A_CURRENT, {15'h0, 1'b1, rv});
		wr(A_SCALE_CFG, 32'h10000800);
		wr(A_MODE_CTRL, 32'h1);
		wr(A_MODE_CTRL, 32'h3);
		rd(A_MODE_CTRL, 32'h1);
		rd(A_STATUS_HOT, 32'h00020424);
		repeat (2 * (AL + 1) * TL) @(posedge pclk);
		rd(A_AVG_SPEED, {17'h0, 4'h1, rv[11:1]});
		wr(A_MODE_CTRL, 32'h12);
		repeat (2 * (AL + 1) * TL) @(posedge pclk);
		rd(A_AVG_SPEED, {12'h0, 4'h1, rv[11:0], 4'h0});
		jog_active <= 1'b1;
		repeat (2 * (AL + 1) * TL) @(posedge pclk);
		rd(A_AVG_SPEED, {16'h0, 4'h1, rv[11:0]});
		stop_test;
	end
endmodule
